// file: design/prxso_status_out.sv
// Purpose: Receive status pins (valid, error, overlap, carrier/comma) per mode.
// Assumes: RECEIVE_DATA and the activity flags come from CLK-domain logic.
// Notes: Receive clock is sampled, its edges pace the valid, error and comma pin updates.
`timescale 1ns/10ps
`include "prxso_regs.svh"
module prxso_status_out
    import prxso_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    input wire logic RECEIVE_CLOCK,
    input wire logic [9:0] RECEIVE_DATA,
    input wire logic RX_VALID,
    input wire logic RX_ERROR,
    input wire logic TX_ACTIVE,
    input wire logic RX_ACTIVE,
    input wire logic COLLISION,
    input wire logic COMMA_DET,
    input wire logic RECEIVE_VALID_PIN_I,
    output logic RECEIVE_VALID_PIN_O,
    output logic RECEIVE_VALID_PIN_OE_N,
    input wire logic RECEIVE_ERROR_PIN_I,
    output logic RECEIVE_ERROR_PIN_O,
    output logic RECEIVE_ERROR_PIN_OE_N,
    input wire logic OVERLAP_PIN_I,
    output logic OVERLAP_PIN_O,
    output logic OVERLAP_PIN_OE_N,
    input wire logic CARRIER_SENSE_I,
    output logic CARRIER_SENSE_O,
    output logic CARRIER_SENSE_OE_N,
    input wire logic TRANSMIT_CLOCK_PIN_I,
    output logic TRANSMIT_CLOCK_PIN_O,
    output logic TRANSMIT_CLOCK_PIN_OE_N
);
    prxso_edge_if e ();

    prxso_boot_e boot_r;
    logic [3:0] settle_r;
    logic drive_en_r;
    logic [3:0] straps_r;
    prxso_mode_e mode_r;
    logic dual_clock_ten_bit_sel_r;
    logic dlb_r;
    logic coltest_r;
    logic dv_r;
    logic er_r;
    logic col_r;
    logic crs_r;
    logic transmit_clock_pin_r;
    logic dv_oen_r;
    logic er_oen_r;
    logic col_oen_r;
    logic crs_oen_r;
    logic transmit_clock_pin_oen_r;
    logic [DATA_W-1:0] rdata_r;
    logic wr_ctrl;
    logic tick;
    logic ten_bit;

    prxso_pin_sync u_sync (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .rx_clock_pin(RECEIVE_CLOCK),
        .strap_pins({CARRIER_SENSE_I, OVERLAP_PIN_I, RECEIVE_ERROR_PIN_I,
                     RECEIVE_VALID_PIN_I}),
        .transmit_clock_pin_pin(TRANSMIT_CLOCK_PIN_I),
        .e(e.src)
    );

    assign wr_ctrl = WR && (ADDR == `PRXSO_CTRL_ADDR);
    assign tick = prxso_tick(mode_r, dual_clock_ten_bit_sel_r, e.rise, e.fall);
    assign ten_bit = prxso_is_tenbit(mode_r);

    // Pins stay undriven until the synchronised straps have settled
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            boot_r <= PRXSO_HOLD;
            settle_r <= 4'h0;
            drive_en_r <= 1'b0;
            straps_r <= 4'h0;
        end else if (CE) begin
            case (boot_r)
                PRXSO_HOLD: begin
                    boot_r <= PRXSO_SETTLE;
                    settle_r <= 4'h0;
                end
                PRXSO_SETTLE: begin
                    settle_r <= settle_r + 4'h1;
                    if (settle_r == `PRXSO_STRAP_SETTLE) begin
                        straps_r <= e.straps;
                        drive_en_r <= 1'b1;
                        boot_r <= PRXSO_DRIVE;
                    end
                end
                default: begin
                    boot_r <= PRXSO_DRIVE;
                end
            endcase
        end
    end

    // Control register; valid strap seeds the Dual_clock_ten_bit_sel
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_r <= prxso_mode_e'(`PRXSO_CTRL_MODE_RST);
            dual_clock_ten_bit_sel_r <= 1'b0;
            dlb_r <= `PRXSO_CTRL_DLB_RST;
            coltest_r <= `PRXSO_CTRL_COLTEST_RST;
        end else if (CE) begin
            if (wr_ctrl) begin
                mode_r <= prxso_mode_of(WDATA[`PRXSO_CTRL_MODE_MSB:`PRXSO_CTRL_MODE_LSB]);
                dual_clock_ten_bit_sel_r <= WDATA[`PRXSO_CTRL_DUAL_CLOCK_TEN_BIT_SEL_BIT];
                dlb_r <= WDATA[`PRXSO_CTRL_DLB_BIT];
                coltest_r <= WDATA[`PRXSO_CTRL_COLTEST_BIT];
            end else if (boot_r == PRXSO_SETTLE && settle_r == `PRXSO_STRAP_SETTLE) begin
                dual_clock_ten_bit_sel_r <= e.straps[0];
            end
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= '0;
        end else if (CE) begin
            rdata_r <= '0;
            if (RD && ADDR == `PRXSO_CTRL_ADDR) begin
                rdata_r[`PRXSO_CTRL_MODE_MSB:`PRXSO_CTRL_MODE_LSB] <= mode_r;
                rdata_r[`PRXSO_CTRL_DUAL_CLOCK_TEN_BIT_SEL_BIT] <= dual_clock_ten_bit_sel_r;
                rdata_r[`PRXSO_CTRL_DLB_BIT] <= dlb_r;
                rdata_r[`PRXSO_CTRL_COLTEST_BIT] <= coltest_r;
            end else if (RD && ADDR == `PRXSO_STAT_ADDR) begin
                rdata_r[`PRXSO_STAT_STRAP_MSB:`PRXSO_STAT_STRAP_LSB] <= straps_r;
                rdata_r[`PRXSO_STAT_DRIVE_BIT] <= drive_en_r;
                rdata_r[`PRXSO_STAT_RECEIVE_CLOCK_BIT] <= e.level;
                rdata_r[`PRXSO_STAT_TRANSMIT_CLOCK_PIN_BIT] <= e.transmit_clock_pin_level;
                rdata_r[`PRXSO_STAT_MODE_MSB:`PRXSO_STAT_MODE_LSB] <= mode_r;
            end
        end
    end

    // Receive valid pin
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dv_r <= 1'b0;
        end else if (CE) begin
            case (mode_r)
                PRXSO_MII, PRXSO_GMII: begin
                    if (e.rise) dv_r <= RX_VALID;
                end
                PRXSO_RGMII: begin
                    if (e.rise) dv_r <= RX_VALID;
                    else if (e.fall) dv_r <= RX_VALID ^ RX_ERROR;
                end
                PRXSO_TBI: begin
                    if (tick) dv_r <= RECEIVE_DATA[8];
                end
                default: begin
                    if (e.rise) dv_r <= RECEIVE_DATA[4];
                    else if (e.fall) dv_r <= RECEIVE_DATA[9];
                end
            endcase
        end
    end

    // Receive error pin
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            er_r <= 1'b0;
        end else if (CE) begin
            if ((mode_r == PRXSO_MII || mode_r == PRXSO_GMII) && e.rise) begin
                er_r <= RX_ERROR;
            end else if (mode_r == PRXSO_TBI && tick) begin
                er_r <= RECEIVE_DATA[9];
            end
        end
    end

    // Overlap follows the CLK domain, not the receive clock
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            col_r <= 1'b0;
        end else if (CE) begin
            if (dlb_r) begin
                col_r <= coltest_r && TX_ACTIVE;
            end else begin
                col_r <= COLLISION;
            end
        end
    end

    // Carrier sense or comma flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            crs_r <= 1'b0;
        end else if (CE) begin
            if (!ten_bit) begin
                crs_r <= TX_ACTIVE || RX_ACTIVE;
            end else if (tick) begin
                crs_r <= COMMA_DET;
            end
        end
    end

    // Even-group clock is the sampled receive clock inverted
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            transmit_clock_pin_r <= 1'b0;
        end else if (CE) begin
            transmit_clock_pin_r <= !e.level;
        end
    end

    // Output enables, all low-active
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dv_oen_r <= 1'b1;
            er_oen_r <= 1'b1;
            col_oen_r <= 1'b1;
            crs_oen_r <= 1'b1;
            transmit_clock_pin_oen_r <= 1'b1;
        end else if (CE) begin
            dv_oen_r <= !drive_en_r;
            er_oen_r <= !drive_en_r || mode_r == PRXSO_RGMII || mode_r == PRXSO_RTBI;
            col_oen_r <= !drive_en_r || ten_bit;
            crs_oen_r <= !drive_en_r;
            transmit_clock_pin_oen_r <= !(drive_en_r && mode_r == PRXSO_TBI && dual_clock_ten_bit_sel_r);
        end
    end

    assign RDATA = rdata_r;
    assign RECEIVE_VALID_PIN_O = dv_r;
    assign RECEIVE_VALID_PIN_OE_N = dv_oen_r;
    assign RECEIVE_ERROR_PIN_O = er_r;
    assign RECEIVE_ERROR_PIN_OE_N = er_oen_r;
    assign OVERLAP_PIN_O = col_r;
    assign OVERLAP_PIN_OE_N = col_oen_r;
    assign CARRIER_SENSE_O = crs_r;
    assign CARRIER_SENSE_OE_N = crs_oen_r;
    assign TRANSMIT_CLOCK_PIN_O = transmit_clock_pin_r;
    assign TRANSMIT_CLOCK_PIN_OE_N = transmit_clock_pin_oen_r;

    chk_straps_undriven: assert property (@(posedge CLK) disable iff (RST)
        CE && !drive_en_r |=> dv_oen_r && er_oen_r && col_oen_r && crs_oen_r)
        else $error("strap pin driven before release");
    chk_strap_latch: assert property (@(posedge CLK) disable iff (RST)
        CE && $rose(drive_en_r) |-> straps_r == $past(e.straps))
        else $error("straps not latched at drive enable");
    chk_gmii_valid: assert property (@(posedge CLK) disable iff (RST)
        CE && e.rise && (mode_r == PRXSO_GMII || mode_r == PRXSO_MII)
        |=> dv_r == $past(RX_VALID))
        else $error("valid not launched on rise");
    chk_rgmii_ctl: assert property (@(posedge CLK) disable iff (RST)
        CE && e.fall && mode_r == PRXSO_RGMII |=> dv_r == ($past(RX_VALID) ^ $past(RX_ERROR)))
        else $error("ddr control wrong on fall");
    chk_dual_clock_ten_bit_sel: assert property (@(posedge CLK) disable iff (RST)
        CE && mode_r == PRXSO_TBI && e.fall |=> dv_r == ($past(dual_clock_ten_bit_sel_r)
            ? $past(RECEIVE_DATA[8]) : $past(dv_r)))
        else $error("tbi valid updated on wrong edge");
    chk_rtbi_split: assert property (@(posedge CLK) disable iff (RST)
        CE && mode_r == PRXSO_RTBI && (e.rise || e.fall)
        |=> dv_r == ($past(e.rise) ? $past(RECEIVE_DATA[4]) : $past(RECEIVE_DATA[9])))
        else $error("rtbi valid halves wrong");
    chk_error_hiz: assert property (@(posedge CLK) disable iff (RST)
        CE && (mode_r == PRXSO_RGMII || mode_r == PRXSO_RTBI) |=> er_oen_r)
        else $error("error pin driven in ddr mode");
    chk_tbi_error: assert property (@(posedge CLK) disable iff (RST)
        CE && mode_r == PRXSO_TBI && e.rise |=> er_r == $past(RECEIVE_DATA[9]))
        else $error("tbi error bit wrong");
    chk_loop_quiet: assert property (@(posedge CLK) disable iff (RST)
        CE && dlb_r && !coltest_r |=> !col_r)
        else $error("overlap not low in loopback");
    chk_overlap_hiz: assert property (@(posedge CLK) disable iff (RST)
        CE && ten_bit |=> col_oen_r)
        else $error("overlap driven in ten-bit mode");
    chk_carrier_or: assert property (@(posedge CLK) disable iff (RST)
        CE && !ten_bit |=> crs_r == ($past(TX_ACTIVE) || $past(RX_ACTIVE)))
        else $error("carrier sense wrong");
    chk_even_clock: assert property (@(posedge CLK) disable iff (RST)
        CE && drive_en_r && mode_r == PRXSO_TBI && dual_clock_ten_bit_sel_r
        |=> !transmit_clock_pin_oen_r && transmit_clock_pin_r == !$past(e.level))
        else $error("even clock not driven");

    // Drive enables and the dual-clock select
    chk_oen_release: assert property (@(posedge CLK) disable iff (RST)
        CE && drive_en_r |=> !dv_oen_r && !crs_oen_r)
        else $error("strap pin not driven after release");
    chk_rate_strap: assert property (@(posedge CLK) disable iff (RST)
        CE && boot_r == PRXSO_SETTLE && settle_r == `PRXSO_STRAP_SETTLE && !wr_ctrl
        |=> dual_clock_ten_bit_sel_r == $past(e.straps[0]))
        else $error("dual-clock select not seeded from strap");
    chk_rate_write: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_ctrl |=> dual_clock_ten_bit_sel_r == $past(WDATA[`PRXSO_CTRL_DUAL_CLOCK_TEN_BIT_SEL_BIT]))
        else $error("dual-clock select not written");
    chk_error_drive: assert property (@(posedge CLK) disable iff (RST)
        CE && drive_en_r
        && (mode_r == PRXSO_MII || mode_r == PRXSO_GMII || mode_r == PRXSO_TBI) |=> !er_oen_r)
        else $error("error pin not driven");
    chk_overlap_drive: assert property (@(posedge CLK) disable iff (RST)
        CE && drive_en_r && !ten_bit |=> !col_oen_r)
        else $error("overlap pin not driven");
    chk_even_hiz: assert property (@(posedge CLK) disable iff (RST)
        CE && !(mode_r == PRXSO_TBI && dual_clock_ten_bit_sel_r) |=> transmit_clock_pin_oen_r)
        else $error("transmit pin driven outside dual-clock mode");

    // Update slots of the status pins
    chk_tbi_rise: assert property (@(posedge CLK) disable iff (RST)
        CE && mode_r == PRXSO_TBI && e.rise |=> dv_r == $past(RECEIVE_DATA[8]))
        else $error("tbi valid not launched on rise");
    chk_rgmii_rise: assert property (@(posedge CLK) disable iff (RST)
        CE && mode_r == PRXSO_RGMII && e.rise |=> dv_r == $past(RX_VALID))
        else $error("ddr control wrong on rise");
    chk_mii_error: assert property (@(posedge CLK) disable iff (RST)
        CE && e.rise && (mode_r == PRXSO_MII || mode_r == PRXSO_GMII)
        |=> er_r == $past(RX_ERROR))
        else $error("error not launched on rise");
    chk_tbi_even: assert property (@(posedge CLK) disable iff (RST)
        CE && mode_r == PRXSO_TBI && dual_clock_ten_bit_sel_r && e.fall |=> er_r == $past(RECEIVE_DATA[9]))
        else $error("tbi error missed on even edge");
    chk_error_hold: assert property (@(posedge CLK) disable iff (RST)
        CE && mode_r == PRXSO_TBI && !tick |=> $stable(er_r))
        else $error("tbi error changed between slots");
    chk_overlap_follow: assert property (@(posedge CLK) disable iff (RST)
        CE && !dlb_r |=> col_r == $past(COLLISION))
        else $error("overlap does not follow collision");
    chk_overlap_test: assert property (@(posedge CLK) disable iff (RST)
        CE && dlb_r && coltest_r |=> col_r == $past(TX_ACTIVE))
        else $error("overlap test behaviour wrong");
    chk_comma_tick: assert property (@(posedge CLK) disable iff (RST)
        CE && ten_bit && tick |=> crs_r == $past(COMMA_DET))
        else $error("comma flag not updated");
    chk_comma_hold: assert property (@(posedge CLK) disable iff (RST)
        CE && ten_bit && !tick |=> $stable(crs_r))
        else $error("comma flag changed between slots");
endmodule : prxso_status_out

// file: design/prxso_regs.svh
// Purpose: Register offsets, field positions, reset values and counts for prxso.
// Assumes: Word-aligned plain register port, 32-bit data.
// Notes: Definitions only.
//
// Summary of operation
// - Status pins are strap inputs during reset
// - MII/GMII receive valid launched on rising edge
// - RGMII puts DDR control on valid pin
// - Normal TBI valid carries bit 8, both clocks
// - Dual-clock bit or valid strap picks TBI
// - One-clock TBI valid bit 8 on rise
// - RTBI valid: bit 4 rise, bit 9 fall
// - MII/GMII receive error launched on rising edge
// - RGMII/RTBI receive error pin is undriven
// - TBI error pin carries receive bit 9
// - Overlap pin high during collision, else low
// - Overlap pin not tied to interface clocks
// - Loopback without test forces overlap low
// - TBI/RTBI leave overlap pin undriven
// - Carrier sense when transmit or receive active
// - TBI/RTBI carrier pin becomes comma flag
// - TBI comma flag update edges follow Dual_clock_ten_bit_sel, RTBI on rise only
// - Rising clock odd groups, even clock even
// - Normal TBI drives even clock on transmit pin
`ifndef PRXSO_REGS_SVH
`define PRXSO_REGS_SVH

`define PRXSO_CTRL_ADDR 8'h00
`define PRXSO_STAT_ADDR 8'h04

`define PRXSO_CTRL_MODE_LSB 0
`define PRXSO_CTRL_MODE_MSB 2
`define PRXSO_CTRL_DUAL_CLOCK_TEN_BIT_SEL_BIT 3
`define PRXSO_CTRL_DLB_BIT 4
`define PRXSO_CTRL_COLTEST_BIT 5

`define PRXSO_STAT_STRAP_LSB 0
`define PRXSO_STAT_STRAP_MSB 3
`define PRXSO_STAT_DRIVE_BIT 4
`define PRXSO_STAT_RECEIVE_CLOCK_BIT 5
`define PRXSO_STAT_TRANSMIT_CLOCK_PIN_BIT 6
`define PRXSO_STAT_MODE_LSB 8
`define PRXSO_STAT_MODE_MSB 10

`define PRXSO_CTRL_MODE_RST 3'h1
`define PRXSO_CTRL_DLB_RST 1'h0
`define PRXSO_CTRL_COLTEST_RST 1'h0
`define PRXSO_STRAP_SETTLE 4'h3

`endif

// file: design/prxso_pkg.sv
// Purpose: Types and shared decode functions for prxso.
// Assumes: Nothing beyond the mode encodings below.
// Notes: Mode codes are Gray along MII-GMII-TBI-RGMII-RTBI.
package prxso_pkg;

    typedef enum logic [2:0] {
        PRXSO_MII = 3'h0,
        PRXSO_GMII = 3'h1,
        PRXSO_TBI = 3'h3,
        PRXSO_RGMII = 3'h2,
        PRXSO_RTBI = 3'h6
    } prxso_mode_e;

    typedef enum logic [1:0] {
        PRXSO_HOLD = 2'h0,
        PRXSO_SETTLE = 2'h1,
        PRXSO_DRIVE = 2'h3
    } prxso_boot_e;

    function automatic logic prxso_is_tenbit(input prxso_mode_e m);
        return (m == PRXSO_TBI) || (m == PRXSO_RTBI);
    endfunction : prxso_is_tenbit

    // Unknown codes fall back to MII
    function automatic prxso_mode_e prxso_mode_of(input logic [2:0] v);
        prxso_mode_e m;
        m = PRXSO_MII;
        case (v)
            3'h1: m = PRXSO_GMII;
            3'h2: m = PRXSO_RGMII;
            3'h3: m = PRXSO_TBI;
            3'h6: m = PRXSO_RTBI;
            default: m = PRXSO_MII;
        endcase
        return m;
    endfunction : prxso_mode_of

    // One update slot of a ten-bit style output
    function automatic logic prxso_tick(input prxso_mode_e m, input logic rate,
                                        input logic rise, input logic fall);
        logic t;
        t = 1'b0;
        if (m == PRXSO_TBI) begin
            t = rise || (rate && fall);
        end else if (m == PRXSO_RTBI) begin
            t = rise;
        end
        return t;
    endfunction : prxso_tick

endpackage : prxso_pkg

// file: design/prxso_edge_if.sv
// Purpose: Carries synchronised pin levels and clock edges to the core.
// Assumes: All members in the CLK domain.
// Notes: rise and fall are one-cycle pulses.
`timescale 1ns/10ps
interface prxso_edge_if;
    logic rise;
    logic fall;
    logic level;
    logic [3:0] straps;
    logic transmit_clock_pin_level;
    modport src (output rise, output fall, output level, output straps, output transmit_clock_pin_level);
    modport dst (input rise, input fall, input level, input straps, input transmit_clock_pin_level);
endinterface : prxso_edge_if

// file: design/prxso_pin_sync.sv
// Purpose: Two-flop synchronisers for pins and receive clock edge finder.
// Assumes: Receive clock well below half the CLK rate.
// Notes: First stage feeds only the second stage.
`timescale 1ns/10ps
module prxso_pin_sync
    import prxso_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rx_clock_pin,
    input wire logic [3:0] strap_pins,
    input wire logic transmit_clock_pin_pin,
    prxso_edge_if.src e
);
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic last_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
        end else if (ce) begin
            meta_r <= {transmit_clock_pin_pin, strap_pins, rx_clock_pin};
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_r <= 1'b0;
        end else if (ce) begin
            last_r <= sync_r[0];
        end
    end

    assign e.level = sync_r[0];
    assign e.rise = sync_r[0] && !last_r;
    assign e.fall = !sync_r[0] && last_r;
    assign e.straps = sync_r[4:1];
    assign e.transmit_clock_pin_level = sync_r[5];
endmodule : prxso_pin_sync

// file: tb/prxso_mac_model.sv
// Purpose: Far-side logic model: pin pulls and input synchronisers.
// Assumes: Pin order valid, error, overlap, carrier, transmit clock.
// Notes: Undriven lines settle to their pull level, never the old value.
`timescale 1ns/10ps
module prxso_mac_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] pin_o,
    input wire logic [4:0] pin_oe_n,
    input wire logic [4:0] pull,
    output logic [4:0] pin,
    output logic overlap_sync,
    output logic carrier_sync
);
    logic [1:0] ovl_r;
    logic [1:0] crs_r;

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin[i] = pin_oe_n[i] ? pull[i] : pin_o[i];
        end
    end

    // Both pins are unrelated to any clock, so two flops before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovl_r <= 2'h0;
            crs_r <= 2'h0;
        end else begin
            ovl_r <= {ovl_r[0], pin[2]};
            crs_r <= {crs_r[0], pin[3]};
        end
    end

    assign overlap_sync = ovl_r[1];
    assign carrier_sync = crs_r[1];
endmodule : prxso_mac_model

// file: tb/prxso_status_out_tb.sv
// Purpose: Self-checking bench for the receive status pins.
// Assumes: Receive clock made here at 128 ns or slower, paced from the core clock.
// Notes: Overlap and carrier are judged through the far-side synchronisers.
`timescale 1ns/10ps
`include "prxso_regs.svh"
module prxso_status_out_tb
    import prxso_pkg::*;
;
    logic clk, rst, ce, wr, rd, receive_clock;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic [9:0] rdat;
    logic rx_valid, rx_error, tx_act, rx_act, coll, comma, ovl_s, crs_s;
    logic [4:0] pin_o, pin_oe_n, pin;
    logic [3:0] straps;
    int n_errors, checked;

    prxso_status_out u_prxso_status_out (
        .CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RECEIVE_CLOCK(receive_clock), .RECEIVE_DATA(rdat), .RX_VALID(rx_valid),
        .RX_ERROR(rx_error), .TX_ACTIVE(tx_act), .RX_ACTIVE(rx_act), .COLLISION(coll),
        .COMMA_DET(comma), .RECEIVE_VALID_PIN_I(pin[0]), .RECEIVE_VALID_PIN_O(pin_o[0]),
        .RECEIVE_VALID_PIN_OE_N(pin_oe_n[0]), .RECEIVE_ERROR_PIN_I(pin[1]),
        .RECEIVE_ERROR_PIN_O(pin_o[1]), .RECEIVE_ERROR_PIN_OE_N(pin_oe_n[1]),
        .OVERLAP_PIN_I(pin[2]), .OVERLAP_PIN_O(pin_o[2]), .OVERLAP_PIN_OE_N(pin_oe_n[2]),
        .CARRIER_SENSE_I(pin[3]), .CARRIER_SENSE_O(pin_o[3]),
        .CARRIER_SENSE_OE_N(pin_oe_n[3]), .TRANSMIT_CLOCK_PIN_I(pin[4]),
        .TRANSMIT_CLOCK_PIN_O(pin_o[4]), .TRANSMIT_CLOCK_PIN_OE_N(pin_oe_n[4])
    );

    prxso_mac_model u_prxso_mac_model (
        .clk(clk), .rst(rst), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pull({1'b0, straps}),
        .pin(pin), .overlap_sync(ovl_s), .carrier_sync(crs_s)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        rv = rdata;
    endtask : reg_rd

    task automatic drive(input logic [9:0] d, input logic v, input logic e, input logic c);
        @(posedge clk);
        rdat <= d;
        rx_valid <= v;
        rx_error <= e;
        comma <= c;
    endtask : drive

    // Launched off the falling core edge so the sampler never races it
    task automatic half(input logic lvl);
        @(negedge clk);
        receive_clock = lvl;
        #62.5;
    endtask : half

    task automatic aset(input logic tx, input logic rx, input logic co);
        @(posedge clk);
        tx_act <= tx;
        rx_act <= rx;
        coll <= co;
        repeat (4) @(posedge clk);
        #1;
    endtask : aset

    task automatic do_reset(input logic [3:0] s);
        rst <= 1'b1;
        straps <= s;
        repeat (3) @(posedge clk);
        chk(pin_oe_n, 5'h1F);
        chk(pin[3:0], s);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(pin_oe_n[3:0], 4'hF);
        repeat (4) @(posedge clk);
    endtask : do_reset

    initial begin
        rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
        receive_clock = 1'b0; rdat = 10'h000; rx_valid = 1'b0; rx_error = 1'b0; tx_act = 1'b0;
        rx_act = 1'b0; coll = 1'b0; comma = 1'b0; straps = 4'h5;
        n_errors = 0;
        checked = 0;
        do_reset(4'h5);
        chk(pin_o[0], 1'b0);
        chk(pin_oe_n, 5'h10);
        reg_rd(`PRXSO_STAT_ADDR);
        chk(rv & 32'h0000_071F, 32'h0000_0115);
        reg_rd(`PRXSO_CTRL_ADDR);
        chk(rv, 32'h0000_0009);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            reg_wr(`PRXSO_CTRL_ADDR, {29'h0, (m == 0) ? PRXSO_MII : PRXSO_GMII});
            drive(10'h000, 1'b1, 1'b1, 1'b0);
            half(1'b1);
            chk(pin_o[1:0], 2'h3);
            chk(pin_oe_n, 5'h10);
            drive(10'h000, 1'b0, 1'b0, 1'b0);
            half(1'b0);
            chk(pin_o[1:0], 2'h3);
            half(1'b1);
            chk(pin_o[1:0], 2'h0);
            half(1'b0);
        end
        aset(1'b0, 1'b0, 1'b1);
        chk({crs_s, ovl_s}, 2'b01);
        aset(1'b1, 1'b0, 1'b0);
        chk({crs_s, ovl_s}, 2'b10);
        aset(1'b0, 1'b1, 1'b0);
        chk({crs_s, ovl_s}, 2'b10);
        aset(1'b0, 1'b0, 1'b0);
        chk({crs_s, ovl_s}, 2'b00);
        reg_wr(`PRXSO_CTRL_ADDR, 32'h0000_0011);
        aset(1'b1, 1'b0, 1'b1);
        chk(ovl_s, 1'b0);
        reg_wr(`PRXSO_CTRL_ADDR, 32'h0000_0031);
        aset(1'b1, 1'b0, 1'b1);
        chk(ovl_s, 1'b1);
        aset(1'b0, 1'b0, 1'b1);
        chk(ovl_s, 1'b0);
        $display("test mii_gmii done");
        reg_wr(`PRXSO_CTRL_ADDR, {29'h0, PRXSO_RGMII});
        drive(10'h000, 1'b1, 1'b1, 1'b0);
        half(1'b1);
        chk(pin_o[0], 1'b1);
        chk(pin_oe_n, 5'h12);
        half(1'b0);
        chk(pin_o[0], 1'b0);
        chk(ovl_s, 1'b1);
        aset(1'b0, 1'b0, 1'b0);
        $display("test rgmii done");
        reg_wr(`PRXSO_CTRL_ADDR, 32'h0000_000B);
        drive(10'h100, 1'b0, 1'b0, 1'b1);
        half(1'b1);
        chk({pin_o[3], pin_o[1:0]}, 3'b101);
        chk(pin_oe_n, 5'h04);
        chk(pin_o[4], 1'b0);
        drive(10'h200, 1'b0, 1'b0, 1'b0);
        half(1'b0);
        chk({pin_o[3], pin_o[1:0]}, 3'b010);
        chk(pin_o[4], 1'b1);
        reg_wr(`PRXSO_CTRL_ADDR, {29'h0, PRXSO_TBI});
        drive(10'h300, 1'b0, 1'b0, 1'b1);
        half(1'b1);
        chk({pin_o[3], pin_o[1:0]}, 3'b111);
        chk(pin_oe_n, 5'h14);
        drive(10'h000, 1'b0, 1'b0, 1'b0);
        half(1'b0);
        chk({pin_o[3], pin_o[1:0]}, 3'b111);
        half(1'b1);
        chk({pin_o[3], pin_o[1:0]}, 3'b000);
        half(1'b0);
        $display("test tbi done");
        reg_wr(`PRXSO_CTRL_ADDR, {29'h0, PRXSO_RTBI});
        drive(10'h010, 1'b0, 1'b0, 1'b1);
        half(1'b1);
        chk({pin_o[3], pin_o[0]}, 2'b11);
        chk(pin_oe_n, 5'h16);
        drive(10'h200, 1'b0, 1'b0, 1'b0);
        half(1'b0);
        chk({pin_o[3], pin_o[0]}, 2'b11);
        half(1'b1);
        chk({pin_o[3], pin_o[0]}, 2'b00);
        drive(10'h000, 1'b0, 1'b0, 1'b0);
        half(1'b0);
        chk(pin_o[0], 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        drive(10'h010, 1'b0, 1'b0, 1'b1);
        half(1'b1);
        chk({pin_o[3], pin_o[0]}, 2'b00);
        @(posedge clk);
        ce <= 1'b1;
        half(1'b1);
        chk({pin_o[3], pin_o[0]}, 2'b11);
        half(1'b0);
        reg_wr(8'h08, 32'hFFFF_FFFF);
        reg_rd(8'h08);
        chk(rv, 32'h0);
        reg_rd(`PRXSO_CTRL_ADDR);
        chk(rv, 32'h0000_0006);
        $display("test rtbi done");
        do_reset(4'h0);
        reg_rd(`PRXSO_CTRL_ADDR);
        chk(rv, 32'h0000_0001);
        $display("test strap_low done");
        results();
    end

    initial begin
        #100000;
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        results();
    end
endmodule : prxso_status_out_tb
